// [tcd_clock_distribution.sv]
// Clock distribution and interface clock formatter of the transceiver.
// Assumes mclk at 50 MHz, reference inputs and mode pins asynchronous.
//
// How it works
// R1: In half duplex the direction pin is an input choosing receive or transmit.
// R2: Clock mode field, bits 7:5 of 0x01, resets to 000, the base modes.
// R3: Optional modes 2, 5, 8 and 10 are selected by programming clock mode.
// R4: Interleaved modes 1, 2, 7, 8, 10 run with 2x or 4x interpolation.
// R5: DAC update clock equals transmit reference times PLL factor.
// R6: Non-interleaved transmit clock is reference times PLL factor over interpolation.
// R7: Interleaved transmit clock is twice reference times PLL factor over interpolation.
// R8: Normal timing: receive clock is receive reference, optionally halved by ADC divider.
// R9: Alternate timing: receive clock is PLL output, optionally halved by ADC divider.
// R10: Aux pin idle outside full duplex unless enabled; enabled gives continuous clock.
// R11: Full duplex aux pin always clocks; enable bit inverts it. Code: in optional full duplex it carries frame sync pulses, enable ignored.
// R12: Bit 1 of 0x01 inverts the interface data clock pin.
// R13: Bit 5 of 0x13 selects rising or falling transmit latch edge.
// R14: Bits 1:0 of 0x13 set interpolation to 1x, 2x or 4x.
// R15: Bit 7 of 0x15 bypasses the PLL when set.
// R16: Bit 5 of 0x15 halves the ADC clock from the receive path clock.
// R17: Bit 4 of 0x15 picks receive reference or PLL output for receive path.
// R18: Bit 3 of 0x15 divides PLL output by five.
// R19: Bits 2:0 of 0x15 select PLL factor 1x, 2x, 4x, 8x or 16x.
// R20: Bit 5 of 0x16 picks buffered reference or PLL clock for aux pin.
// R21: In half duplex and clone, data clock pin follows direction: transmit or receive.
// R22: Software bypasses PLL below 16 MHz input or 32 MHz output.
`timescale 1ns/1ps
`include "tcd_clock_regs.svh"
`default_nettype none

module tcd_clock_distribution #(
   parameter int PER_W = `TCD_PER_W
) (
   input  wire logic        mclk,                       // System clock, 50 MHz.
   input  wire logic        resetn,                     // Asynchronous reset, active low.
   input  wire logic [5:0]  reg_addr,                   // Register address.
   input  wire logic [7:0]  reg_wdata,                  // Register write data.
   input  wire logic        reg_write,                  // Write strobe, one cycle.
   output logic      [7:0]  reg_rdata,                  // Read data of reg_addr, registered.
   input  wire logic        rx_reference_input,         // Receive reference pin.
   input  wire logic        tx_reference_input,         // Transmit reference pin.
   input  wire logic        duplex_select,              // High selects full duplex.
   input  wire logic        bus_width_select,           // High selects 12-bit half duplex.
   input  wire logic        direction_select_pin,       // Half duplex: high is transmit.
   output logic             aux_clock_pin,              // Aux clock pin level.
   output logic             aux_clock_pin_oe_n,         // Aux pin enable, low drives.
   output logic             interface_data_clock_pin,   // Interface data clock level.
   output logic             tx_latch_falling,           // Transmit data latched on falling edge.
   output logic             rx_frame_sync,              // Receive frame sync, optional full duplex.
   output tcd_clock_pkg::tcd_ticks_t ticks,             // Rising-edge pulses of derived clocks.
   output logic             interleaved_tx              // Transmit data interleaved in this mode.
);

   // -----------------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------------
   logic [7:0] interface_clock_config;
   logic [7:0] tx_path_config;
   logic [7:0] pll_timing_config;
   logic [7:0] aux_clock_source_config;
   tcd_clock_pkg::tcd_cfg_t cfg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         interface_clock_config  <= `TCD_RST_REG; // R2
         tx_path_config          <= `TCD_RST_REG;
         pll_timing_config       <= `TCD_RST_REG;
         aux_clock_source_config <= `TCD_RST_REG;
      end else if (reg_write) begin
         case (reg_addr)
            `TCD_OFS_IFACE_CLK:  interface_clock_config  <= reg_wdata;
            `TCD_OFS_TX_PATH:    tx_path_config          <= reg_wdata;
            `TCD_OFS_PLL_TIMING: pll_timing_config       <= reg_wdata;
            `TCD_OFS_AUX_SRC:    aux_clock_source_config <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            `TCD_OFS_IFACE_CLK:  reg_rdata <= interface_clock_config;
            `TCD_OFS_TX_PATH:    reg_rdata <= tx_path_config;
            `TCD_OFS_PLL_TIMING: reg_rdata <= pll_timing_config;
            `TCD_OFS_AUX_SRC:    reg_rdata <= aux_clock_source_config;
            default:             reg_rdata <= 8'h00;
         endcase
      end
   end

   always_comb begin
      cfg.clk_mode    = interface_clock_config[`TCD_CLK_MODE_HI:`TCD_CLK_MODE_LO];
      cfg.aux_enable  = interface_clock_config[`TCD_AUX_ENABLE_BIT];
      cfg.dclk_invert = interface_clock_config[`TCD_DCLK_INVERT_BIT];
      cfg.tx_latch_falling = tx_path_config[`TCD_TX_FALL_BIT]; // R13
      cfg.interp      = tx_path_config[`TCD_INTERP_HI:`TCD_INTERP_LO]; // R14
      cfg.pll_bypass  = pll_timing_config[`TCD_PLL_BYPASS_BIT];
      cfg.adc_div     = pll_timing_config[`TCD_ADC_DIV_BIT];
      cfg.alt_timing  = pll_timing_config[`TCD_ALT_TIMING_BIT];
      cfg.pll_fifth_divider_bit = pll_timing_config[`TCD_PLL_FIFTH_DIVIDER_BIT_BIT];
      cfg.pll_mult    = pll_timing_config[`TCD_PLL_MULT_HI:`TCD_PLL_MULT_LO];
      cfg.aux_pll_source = aux_clock_source_config[`TCD_AUX_PLL_SRC_BIT];
   end

   // -----------------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------------
   localparam int NPIN = 5;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_meta;
   logic [NPIN-1:0] pin_sync;

   assign pin_raw = {direction_select_pin, bus_width_select, duplex_select,
                     tx_reference_input, rx_reference_input};

   for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            pin_meta[i] <= 1'b0;
            pin_sync[i] <= 1'b0;
         end else begin
            pin_meta[i] <= pin_raw[i];
            pin_sync[i] <= pin_meta[i];
         end
      end
   end

   logic rx_ref;
   logic tx_ref;
   logic dir_tx;
   logic rx_ref_d;
   logic tx_ref_d;
   assign rx_ref = pin_sync[0];
   assign tx_ref = pin_sync[1];
   assign dir_tx = pin_sync[4]; // R1

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rx_ref_d <= 1'b0;
         tx_ref_d <= 1'b0;
      end else begin
         rx_ref_d <= rx_ref;
         tx_ref_d <= tx_ref;
      end
   end

   logic tx_ref_rise;
   logic tx_ref_edge;
   logic rx_ref_edge;
   assign tx_ref_rise = tx_ref & ~tx_ref_d;
   assign tx_ref_edge = tx_ref ^ tx_ref_d;
   assign rx_ref_edge = rx_ref ^ rx_ref_d;

   // -----------------------------------------------------------------------
   // Mode decode
   // -----------------------------------------------------------------------
   tcd_clock_pkg::tcd_iface_mode_t mode;
   logic optional_mode;

   always_comb begin
      optional_mode = (cfg.clk_mode == `TCD_CLK_MODE_OPTION); // R3
      if (cfg.clk_mode == `TCD_CLK_MODE_CLONE && !pin_sync[2])
         mode = tcd_clock_pkg::TCD_CLONE_MODE;
      else if (pin_sync[2])
         mode = tcd_clock_pkg::TCD_FULL_DUPLEX_MODE;
      else if (pin_sync[3])
         mode = tcd_clock_pkg::TCD_HALF_DUPLEX_NARROW_MODE;
      else
         mode = tcd_clock_pkg::TCD_HALF_DUPLEX_WIDE_MODE;
   end

   // Only the 24-bit half duplex mode outside clone mode carries parallel transmit data.
   assign interleaved_tx = (mode != tcd_clock_pkg::TCD_HALF_DUPLEX_WIDE_MODE);

   // -----------------------------------------------------------------------
   // PLL model
   // -----------------------------------------------------------------------
   // The reference period is measured in mclk cycles and the PLL emits
   // half-period events at a fraction of it; a limitation is that the
   // multiplied rate cannot exceed half of mclk.
   logic [PER_W-1:0] per_cnt;
   logic [PER_W-1:0] per_meas;
   logic [PER_W-1:0] step;
   logic [PER_W-1:0] step_cnt;
   logic [2:0]       mult_log2;
   logic             pll_ev;

   assign mult_log2 = (cfg.pll_mult > `TCD_PLL_MULT_MAX) ? `TCD_PLL_MULT_MAX
                                                          : cfg.pll_mult; // R19

   always_comb begin
      step = per_meas >> (mult_log2 + 3'h1);
      if (step == '0)
         step = PER_W'(1);
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         per_cnt  <= '0;
         per_meas <= '0;
      end else if (tx_ref_rise) begin
         per_cnt  <= PER_W'(1);
         per_meas <= per_cnt;
      end else if (per_cnt != '1) begin
         per_cnt <= per_cnt + PER_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         step_cnt <= '0;
         pll_ev   <= 1'b0;
      end else if (tx_ref_rise || step_cnt + PER_W'(1) >= step) begin
         step_cnt <= '0;
         pll_ev   <= 1'b1;
      end else begin
         step_cnt <= step_cnt + PER_W'(1);
         pll_ev   <= 1'b0;
      end
   end

   logic [2:0] div5_cnt;
   logic       div5_ev;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div5_cnt <= 3'h0;
      end else if (pll_ev) begin
         div5_cnt <= (div5_cnt == `TCD_DIV5_LAST) ? 3'h0 : div5_cnt + 3'h1; // R18
      end
   end
   assign div5_ev = pll_ev && div5_cnt == `TCD_DIV5_LAST;

   logic pll_out_ev;
   logic sys_ev;
   logic sys_lvl;
   assign pll_out_ev = cfg.pll_fifth_divider_bit ? div5_ev : pll_ev; // R18
   // Software keeps the PLL in bypass for slow references.
   assign sys_ev = cfg.pll_bypass ? tx_ref_edge : pll_out_ev; // R15 R22

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         sys_lvl <= 1'b0;
      else if (sys_ev)
         sys_lvl <= ~sys_lvl;
   end

   // -----------------------------------------------------------------------
   // Transmit clocks
   // -----------------------------------------------------------------------
   logic [1:0] eff_interp;
   logic [1:0] tx_last;
   logic [1:0] tx_cnt;
   logic       tx_ev;
   logic       tx_lvl;

   // Interleaved modes never run at 1x, so a 1x or reserved code is raised to 2x.
   always_comb begin
      eff_interp = cfg.interp;
      if (cfg.interp == 2'h3 || (interleaved_tx && cfg.interp == `TCD_INTERP_1X))
         eff_interp = `TCD_INTERP_2X; // R4
      case (eff_interp)
         `TCD_INTERP_4X: tx_last = interleaved_tx ? 2'h1 : 2'h3; // R6 R7
         `TCD_INTERP_2X: tx_last = interleaved_tx ? 2'h0 : 2'h1; // R6 R7
         default:        tx_last = 2'h0;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_cnt <= 2'h0;
      end else if (sys_ev) begin
         tx_cnt <= (tx_cnt >= tx_last) ? 2'h0 : tx_cnt + 2'h1;
      end
   end
   assign tx_ev = sys_ev && tx_cnt >= tx_last;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         tx_lvl <= 1'b0;
      else if (tx_ev)
         tx_lvl <= ~tx_lvl;
   end

   // -----------------------------------------------------------------------
   // Receive clocks
   // -----------------------------------------------------------------------
   logic rx_path_ev;
   logic rx_div_ph;
   logic rx_ev;
   logic rx_lvl;

   assign rx_path_ev = cfg.alt_timing ? sys_ev : rx_ref_edge; // R8 R9 R17

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         rx_div_ph <= 1'b0;
      else if (rx_path_ev)
         rx_div_ph <= ~rx_div_ph;
   end
   assign rx_ev = rx_path_ev && (!cfg.adc_div || rx_div_ph); // R16

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         rx_lvl <= 1'b0;
      else if (rx_ev)
         rx_lvl <= ~rx_lvl;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ticks <= '0;
      end else begin
         ticks.dac_update_tick <= sys_ev && !sys_lvl; // R5
         ticks.tx_data_tick    <= tx_ev && !tx_lvl;
         ticks.rx_clock_tick   <= rx_ev && !rx_lvl;
         ticks.adc_clock_tick  <= rx_ev && !rx_lvl;
      end
   end

   // -----------------------------------------------------------------------
   // Interface pin formatter
   // -----------------------------------------------------------------------
   logic fd;
   logic aux_src;
   assign fd      = (mode == tcd_clock_pkg::TCD_FULL_DUPLEX_MODE);
   assign aux_src = cfg.aux_pll_source ? sys_lvl : rx_ref; // R20

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aux_clock_pin      <= 1'b0;
         aux_clock_pin_oe_n <= 1'b1;
         rx_frame_sync      <= 1'b0;
      end else if (fd) begin
         aux_clock_pin_oe_n <= 1'b0; // R11
         rx_frame_sync      <= optional_mode && rx_ev && !rx_lvl;
         if (optional_mode)
            aux_clock_pin <= optional_mode && rx_ev && !rx_lvl;
         else
            aux_clock_pin <= rx_ref ^ cfg.aux_enable; // R11
      end else begin
         rx_frame_sync      <= 1'b0;
         aux_clock_pin_oe_n <= ~cfg.aux_enable; // R10
         aux_clock_pin      <= cfg.aux_enable & aux_src; // R10
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         interface_data_clock_pin <= 1'b0;
      else if (fd)
         interface_data_clock_pin <= tx_lvl ^ cfg.dclk_invert; // R12
      else
         interface_data_clock_pin <= (dir_tx ? tx_lvl : rx_lvl) ^ cfg.dclk_invert; // R21
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         tx_latch_falling <= 1'b0;
      else
         tx_latch_falling <= cfg.tx_latch_falling; // R13
   end

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   a_mode_reset_default: assert property (@(posedge mclk) $rose(resetn) |-> // R2
      cfg.clk_mode == `TCD_CLK_MODE_DEFAULT) else $error("clock mode not default");
   a_interleave_interp: assert property (@(posedge mclk) disable iff (!resetn) // R4
      interleaved_tx |-> eff_interp != `TCD_INTERP_1X) else $error("interleaved at 1x");
   a_dac_tick_rate: assert property (@(posedge mclk) disable iff (!resetn) // R5
      ticks.dac_update_tick |=> !ticks.dac_update_tick) else $error("dac tick repeats");
   a_tx_follows_sys: assert property (@(posedge mclk) disable iff (!resetn) // R6
      tx_ev |-> sys_ev) else $error("tx event without system event");
   a_rx_alt_source: assert property (@(posedge mclk) disable iff (!resetn) // R9
      cfg.alt_timing && rx_path_ev |-> sys_ev) else $error("alt rx not from pll");
   a_adc_halves: assert property (@(posedge mclk) disable iff (!resetn) // R16
      cfg.adc_div && rx_path_ev && !rx_div_ph |-> !rx_ev) else $error("adc divider open");
   a_aux_fd_driven: assert property (@(posedge mclk) disable iff (!resetn) // R11
      fd |=> !aux_clock_pin_oe_n || !$past(resetn)) else $error("aux undriven in fd");
   a_aux_hd_idle: assert property (@(posedge mclk) disable iff (!resetn) // R10
      !fd && !cfg.aux_enable ##1 $stable(cfg) && !fd |-> aux_clock_pin_oe_n)
      else $error("aux driven while disabled");
   a_dclk_invert: assert property (@(posedge mclk) disable iff (!resetn) // R12
      fd ##1 fd |-> interface_data_clock_pin == ($past(tx_lvl) ^ $past(cfg.dclk_invert)))
      else $error("data clock polarity wrong");
   a_div5_count: assert property (@(posedge mclk) disable iff (!resetn) // R18
      div5_cnt <= `TCD_DIV5_LAST) else $error("divide by five overrun");

endmodule

`default_nettype wire

// [tcd_clock_regs.svh]
// Register offsets, field positions, reset values and counts of the
// transceiver clock distribution block.
// Assumes inclusion by its bare name from the block's module.
`ifndef TCD_CLOCK_REGS_SVH
`define TCD_CLOCK_REGS_SVH

// -----------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------
`define TCD_OFS_IFACE_CLK     6'h01
`define TCD_OFS_TX_PATH       6'h13
`define TCD_OFS_PLL_TIMING    6'h15
`define TCD_OFS_AUX_SRC       6'h16

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define TCD_CLK_MODE_HI       7
`define TCD_CLK_MODE_LO       5
`define TCD_AUX_ENABLE_BIT    2
`define TCD_DCLK_INVERT_BIT   1
`define TCD_TX_FALL_BIT       5
`define TCD_INTERP_HI         1
`define TCD_INTERP_LO         0
`define TCD_PLL_BYPASS_BIT    7
`define TCD_ADC_DIV_BIT       5
`define TCD_ALT_TIMING_BIT    4
`define TCD_PLL_FIFTH_DIVIDER_BIT_BIT      3
`define TCD_PLL_MULT_HI       2
`define TCD_PLL_MULT_LO       0
`define TCD_AUX_PLL_SRC_BIT   5

// -----------------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------------
`define TCD_RST_REG           8'h00
`define TCD_CLK_MODE_DEFAULT  3'h0
`define TCD_CLK_MODE_OPTION   3'h1
`define TCD_CLK_MODE_CLONE    3'h2
`define TCD_INTERP_1X         2'h0
`define TCD_INTERP_2X         2'h1
`define TCD_INTERP_4X         2'h2
`define TCD_PLL_MULT_MAX      3'h4
`define TCD_DIV5_LAST         3'h4
`define TCD_PER_W             16

`endif

// [tcd_clock_pkg.sv]
// Types shared by the clock distribution block.
// Assumes tcd_clock_regs.svh is on the include path.
`default_nettype none

package tcd_clock_pkg;

   // -----------------------------------------------------------------------
   // Interface operating modes
   // -----------------------------------------------------------------------
   typedef enum logic [1:0] {
      TCD_FULL_DUPLEX_MODE        = 2'h0,
      TCD_HALF_DUPLEX_WIDE_MODE   = 2'h1,
      TCD_HALF_DUPLEX_NARROW_MODE = 2'h2,
      TCD_CLONE_MODE              = 2'h3
   } tcd_iface_mode_t;

   // -----------------------------------------------------------------------
   // Decoded configuration fields
   // -----------------------------------------------------------------------
   typedef struct packed {
      logic [2:0] clk_mode;
      logic       aux_enable;
      logic       dclk_invert;
      logic       tx_latch_falling;
      logic [1:0] interp;
      logic       pll_bypass;
      logic       adc_div;
      logic       alt_timing;
      logic       pll_fifth_divider_bit;
      logic [2:0] pll_mult;
      logic       aux_pll_source;
   } tcd_cfg_t;

   typedef struct packed {
      logic dac_update_tick;
      logic tx_data_tick;
      logic rx_clock_tick;
      logic adc_clock_tick;
   } tcd_ticks_t;

endpackage

`default_nettype wire

// [tcd_far_end_model.sv]
// Far-side model: reference oscillators and the back end driving the direction pin.
// Assumes a 50 MHz mclk on the bench, so references are 64 and 128 mclk periods.
`timescale 1ns/1ps
`default_nettype none

module tcd_far_end_model (
   input  wire logic dir_tx,   // Bench choice, high transmits.
   output var  logic tx_ref,   // Transmit reference.
   output var  logic rx_ref,   // Receive reference.
   output logic      dir_pin   // Direction pin into the block.
);
   // Odd offsets keep reference edges away from mclk edges.
   initial begin
      tx_ref = 1'b0;
      rx_ref = 1'b0;
      fork
         #3 forever #640 tx_ref = ~tx_ref;
         #7 forever #1280 rx_ref = ~rx_ref;
      join
   end

   assign dir_pin = dir_tx;
endmodule

`default_nettype wire

// [transceiver_clock_distribution_tb.sv]
// Self-checking bench of the clock distribution block.
// Assumes the far-end model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module transceiver_clock_distribution_tb;
   logic                      mclk, resetn, reg_write, fd, bw, dir_tx, clr;
   logic [5:0]                reg_addr;
   logic [7:0]                reg_wdata, reg_rdata, rb;
   logic                      aux_o, aux_oe_n, dclk, txf, rsync, il, txr, rxr, dpin;
   logic                      dclk_q, aux_q;
   tcd_clock_pkg::tcd_ticks_t ticks;
   logic [31:0]               seed, r;
   int                        fails, total_checks, n_dac, n_tx, n_rx, n_adc, n_dclk, n_aux;
   int                        n_rsy;

   tcd_far_end_model far_u (.dir_tx(dir_tx), .tx_ref(txr), .rx_ref(rxr), .dir_pin(dpin));

   tcd_clock_distribution dut_u (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
      .rx_reference_input(rxr), .tx_reference_input(txr), .duplex_select(fd),
      .bus_width_select(bw), .direction_select_pin(dpin), .aux_clock_pin(aux_o),
      .aux_clock_pin_oe_n(aux_oe_n), .interface_data_clock_pin(dclk),
      .tx_latch_falling(txf), .rx_frame_sync(rsync), .ticks(ticks), .interleaved_tx(il));

   // -----------------------------------------------------------------------
   // Clock and edge counters
   // -----------------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      dclk_q <= dclk;
      aux_q <= aux_o;
      if (clr) begin
         {n_dac, n_tx, n_rx, n_adc, n_dclk, n_aux, n_rsy} <= '0;
      end else begin
         n_dac <= n_dac + ticks.dac_update_tick;
         n_tx <= n_tx + ticks.tx_data_tick;
         n_rx <= n_rx + ticks.rx_clock_tick;
         n_adc <= n_adc + ticks.adc_clock_tick;
         n_dclk <= n_dclk + (dclk & ~dclk_q);
         n_aux <= n_aux + (aux_o & ~aux_q);
         n_rsy <= n_rsy + rsync;
      end
   end

   // -----------------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Ticks expected in a window of eight transmit reference periods.
   function automatic int pll_n(input logic [7:0] p);
      int f;
      f = p[7] ? 1 : (1 << ((p[2:0] > 3'h4) ? 4 : p[2:0]));
      return p[3] ? (8 * f) / 5 : 8 * f;
   endfunction

   task automatic print_verdict();
      if (fails == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   task automatic near(input int got, input int exp, input int tol, input string msg);
      chk((got >= exp - tol) && (got <= exp + tol), msg);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge mclk);
      reg_write = 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(negedge mclk);
      reg_addr = a;
      repeat (2) @(negedge mclk);
      chk(reg_rdata === exp, "register readback");
   endtask

   // One configuration: program, settle, count for 512 cycles, compare rates.
   task automatic run_cfg(input logic [7:0] ic, tp, pt, ax, input logic f, b, d);
      int dac, txe, rxe, rxp, tol, ip;
      logic ilv;
      fd = f;
      bw = b;
      dir_tx = d;
      wr(6'h01, ic);
      wr(6'h13, tp);
      wr(6'h15, pt);
      wr(6'h16, ax);
      rd(6'h01, ic);
      rd(6'h15, pt);
      repeat (256) @(negedge mclk);
      clr = 1'b1;
      @(negedge mclk);
      clr = 1'b0;
      repeat (512) @(negedge mclk);
      dac = pll_n(pt);
      ilv = f | b;
      ip = (tp[1:0] == 2'h2) ? 4 : ((tp[1:0] == 2'h0 && !ilv) ? 1 : 2);
      txe = dac * (ilv ? 2 : 1) / ip;
      // The receive clock itself is scaled by the ADC divider, not only the ADC clock.
      rxp = pt[4] ? dac : 4;
      rxe = pt[5] ? rxp / 2 : rxp;
      tol = pt[3] ? 2 : 1;
      near(n_dac, dac, tol, "dac update rate");
      near(n_tx, txe, tol, "tx data rate");
      near(n_rx, rxe, tol, "rx clock rate");
      near(n_adc, rxe, tol, "adc clock rate");
      near(n_rsy, (f && ic[7:5] == 3'h1) ? rxe : 0, tol, "rx frame sync rate");
      chk(il === ilv, "interleave flag");
      chk(txf === tp[5], "tx latch edge");
      near(n_dclk, (f | d) ? txe : rxe, tol, "data clock pin rate");
      if (f && ic[7:5] == 3'h0) begin
         chk(aux_oe_n === 1'b0, "aux pin not driven in full duplex");
         near(n_aux, 4, 1, "aux pin rate in full duplex");
      end else if (f) begin
         chk(aux_oe_n === 1'b0, "aux pin not driven in optional full duplex");
         near(n_aux, rxe, tol, "aux sync rate in optional full duplex");
      end else begin
         chk(aux_oe_n === ~ic[2], "aux pin enable");
         if (ic[2]) near(n_aux, ax[5] ? dac : 4, tol, "aux pin source rate");
      end
   endtask

   // -----------------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------------
   initial begin
      {resetn, reg_write, fd, bw, dir_tx, clr, reg_addr, reg_wdata} = '0;
      seed = 32'ha9ef5d5e;
      repeat (10) @(negedge mclk);
      chk(aux_oe_n === 1'b1 && ticks === 4'h0, "outputs during reset");
      resetn = 1'b1;
      rd(6'h01, 8'h00);
      rd(6'h13, 8'h00);
      rd(6'h15, 8'h00);
      rd(6'h16, 8'h00);
      wr(6'h02, 8'hff);
      rd(6'h02, 8'h00);
      run_cfg(8'h00, 8'h22, 8'h04, 8'h00, 1'b1, 1'b0, 1'b0);
      run_cfg(8'h24, 8'h00, 8'h80, 8'h20, 1'b0, 1'b0, 1'b0);
      run_cfg(8'h46, 8'h21, 8'h3c, 8'h00, 1'b0, 1'b1, 1'b1);
      run_cfg(8'h20, 8'h01, 8'h22, 8'h00, 1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 18; i++) begin
         r = xs();
         run_cfg({r[3] ? 3'h1 : ((!r[0] && r[1] && r[4]) ? 3'h2 : 3'h0), 2'h0, r[15], r[16],
                  1'b0},
                 {2'h0, r[14], 3'h0, (r[0] | r[1]) ? (r[12] ? 2'h2 : 2'h1) : r[13:12]},
                 {r[8], 1'b0, r[10], r[9], r[7:5] == 3'h4 && !r[8] && r[11], r[7:5]},
                 {2'h0, r[17], 5'h00}, r[0], r[1], r[2]);
      end
      print_verdict();
   end

   initial begin
      repeat (40000) @(posedge mclk);
      fails++;
      print_verdict();
   end
endmodule

`default_nettype wire
